/* File: hw/gpcr_pkg.sv */
package gpcr_pkg;

  // ---------------------------------------------------------------------------
  // Configuration register space
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PORT_B_DIRECTION_OFS       = 8'h1E;
  localparam logic [7:0] PORT_B_FUNCTION_SELECT_OFS = 8'h1F;
  localparam logic [7:0] PORT_C_PULLUP_ENABLE_OFS   = 8'h20;
  localparam logic [7:0] PORT_C_MODE_OPTION_OFS     = 8'h21;
  localparam logic [7:0] PORT_C_DIRECTION_OFS       = 8'h22;
  localparam logic [7:0] PORT_C_FUNCTION_SELECT_OFS = 8'h23;

  // ---------------------------------------------------------------------------
  // Input and output register spaces
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PORT_A_IDX = 8'h00;
  localparam logic [7:0] PORT_B_IDX = 8'h01;
  localparam logic [7:0] PORT_C_IDX = 8'h02;

  // ---------------------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PORT_C_MASK    = 8'h3F;
  localparam logic [7:0] CFG_RESET      = 8'h00;
  localparam logic [7:0] DRIVE_RESET    = 8'h00;
  localparam int         PC_TMR_RST_BIT = 5;
  localparam int         PC_TX_BIT      = 4;
  localparam int         PC_SS_BIT      = 3;
  localparam int         PC_MISO_BIT    = 2;
  localparam int         PC_MOSI_BIT    = 1;
  localparam int         PC_SCK_BIT     = 0;
  localparam int         PB_VREF_BIT    = 0;

  // Pin mode code, ordered {pull-up, option, direction}.
  typedef enum logic [2:0] {
    GPCR_IN_HIZ    = 3'h0,
    GPCR_OUT_PP    = 3'h1,
    GPCR_IRQ       = 3'h2,
    GPCR_OUT_OD    = 3'h3,
    GPCR_IN_PU     = 3'h4,
    GPCR_OUT_PU    = 3'h5,
    GPCR_IRQ_PU    = 3'h6,
    GPCR_OUT_WEAK  = 3'h7
  } gpcr_mode_t;

endpackage

/* File: hw/gpcr_pin_cell.sv */
// Pad control for one pin: decodes the latched mode into drive controls.
module gpcr_pin_cell (
  input  wire logic           dir_i,
  input  wire logic           pullup_i,
  input  wire logic           option_i,
  input  wire logic           drive_i,
  input  wire logic           pad_in_i,
  output logic                pad_o,
  output logic                pad_oe_o,
  output logic                pull_en_o,
  output logic                weak_o,
  output logic                irq_en_o,
  output logic                sample_o
);

  gpcr_pkg::gpcr_mode_t mode;

  always_comb begin
    mode      = gpcr_pkg::gpcr_mode_t'({pullup_i, option_i, dir_i});
    pad_o     = drive_i;
    pad_oe_o  = 1'b0;
    pull_en_o = pullup_i;
    weak_o    = 1'b0;
    irq_en_o  = 1'b0;
    unique case (mode)
      gpcr_pkg::GPCR_IN_HIZ,
      gpcr_pkg::GPCR_IN_PU: begin
      end
      gpcr_pkg::GPCR_IRQ,
      gpcr_pkg::GPCR_IRQ_PU: begin
        irq_en_o = 1'b1;
      end
      gpcr_pkg::GPCR_OUT_PP,
      gpcr_pkg::GPCR_OUT_PU: begin
        pad_oe_o = 1'b1;
      end
      gpcr_pkg::GPCR_OUT_OD: begin
        // Open drain only pulls low; a high level is left to the line.
        pad_o    = 1'b0;
        pad_oe_o = ~drive_i;
      end
      gpcr_pkg::GPCR_OUT_WEAK: begin
        pad_oe_o = 1'b1;
        weak_o   = 1'b1;
      end
    endcase
    // An output pin reads back its own buffer.
    sample_o = dir_i ? drive_i : pad_in_i;
  end

endmodule

/* File: hw/gpcr_port.sv */
// Configuration, shadow latch and output buffer of one port.
module gpcr_port #(
  parameter int         WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] mask_i,
  input  wire logic             pu_we_i,
  input  wire logic             or_we_i,
  input  wire logic             dir_we_i,
  input  wire logic             out_we_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic [WIDTH-1:0] pad_in_i,
  output logic      [WIDTH-1:0] pu_reg_o,
  output logic      [WIDTH-1:0] or_reg_o,
  output logic      [WIDTH-1:0] dir_o,
  output logic      [WIDTH-1:0] pad_o,
  output logic      [WIDTH-1:0] pad_oe_o,
  output logic      [WIDTH-1:0] pull_en_o,
  output logic      [WIDTH-1:0] weak_o,
  output logic      [WIDTH-1:0] irq_en_o,
  output logic      [WIDTH-1:0] sample_o
);

  typedef struct packed {
    logic [WIDTH-1:0] pu;
    logic [WIDTH-1:0] opt;
    logic [WIDTH-1:0] pu_act;
    logic [WIDTH-1:0] opt_act;
    logic [WIDTH-1:0] dir;
    logic [WIDTH-1:0] drive;
  } gpcr_port_t;

  gpcr_port_t s_q;
  gpcr_port_t s_d;

  always_comb begin
    s_d = s_q;
    if (pu_we_i) begin
      s_d.pu = wdata_i & mask_i;
    end
    if (or_we_i) begin
      s_d.opt = wdata_i & mask_i;
    end
    if (dir_we_i) begin
      s_d.dir     = wdata_i & mask_i;
      s_d.pu_act  = s_q.pu;
      s_d.opt_act = s_q.opt;
      if (pu_we_i) begin
        s_d.pu_act = wdata_i & mask_i;
      end
      if (or_we_i) begin
        s_d.opt_act = wdata_i & mask_i;
      end
    end
    if (out_we_i) begin
      s_d.drive = wdata_i & mask_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pu_reg_o = s_q.pu;
  assign or_reg_o = s_q.opt;
  assign dir_o    = s_q.dir;

  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    gpcr_pin_cell u_cell (
      .dir_i     (s_q.dir[i]),
      .pullup_i  (s_q.pu_act[i]),
      .option_i  (s_q.opt_act[i]),
      .drive_i   (s_q.drive[i]),
      .pad_in_i  (pad_in_i[i] & mask_i[i]),
      .pad_o     (pad_o[i]),
      .pad_oe_o  (pad_oe_o[i]),
      .pull_en_o (pull_en_o[i]),
      .weak_o    (weak_o[i]),
      .irq_en_o  (irq_en_o[i]),
      .sample_o  (sample_o[i])
    );
  end

endmodule

/* File: hw/gpcr_top.sv */
// Behaviour
// - Direction bit: zero input, one output.
// - Port B select routes pin to analog channel.
// - Port C select routes pins to peripherals.
// - Port C pull-up bits five to zero.
// - Port C option bits select pin mode.
// - Port C direction has six bits only.
// - Config registers read/write, reset to zero.
// - Input registers read pin levels sampled at the previous clock edge.
// - Output register writes drive output pins; ports B and C take cfg_wdata_i if a config write is in the same cycle.
// - Input and output spaces separate, index per port.
// - Mode decoded from pull-up, option, direction.
// - Pull-up, option take effect on direction write.
// - Output pins read back their buffer.
module gpcr_top (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Configuration register space.
  input  wire logic [7:0] cfg_addr_i,
  input  wire logic       cfg_we_i,
  input  wire logic [7:0] cfg_wdata_i,
  output logic      [7:0] cfg_rdata_o,
  // Input register space.
  input  wire logic [7:0] in_addr_i,
  output logic      [7:0] in_rdata_o,
  // Output register space.
  input  wire logic [7:0] out_addr_i,
  input  wire logic       out_we_i,
  input  wire logic [7:0] out_wdata_i,
  // Port A pins: direction comes from the device's own port A setup, drive from the port A output register.
  input  wire logic [7:0] port_a_pad_i,
  input  wire logic [7:0] port_a_dir_i,
  output logic      [7:0] port_a_pad_o,
  // Port B pins.
  input  wire logic [7:0] port_b_pad_i,
  output logic      [7:0] port_b_pad_o,
  output logic      [7:0] port_b_pad_oe_o,
  output logic      [7:0] port_b_pull_en_o,
  output logic      [7:0] port_b_weak_o,
  output logic      [7:0] port_b_irq_en_o,
  output logic      [7:0] port_b_analog_en_o,
  output logic            adc_vref_en_o,
  // Port C pins.
  input  wire logic [7:0] port_c_pad_i,
  output logic      [7:0] port_c_pad_o,
  output logic      [7:0] port_c_pad_oe_o,
  output logic      [7:0] port_c_pull_en_o,
  output logic      [7:0] port_c_weak_o,
  // Peripheral routing on port C.
  input  wire logic       uart_tx_i,
  input  wire logic       spi_miso_i,
  input  wire logic       spi_mosi_i,
  input  wire logic       spi_sck_i,
  output logic            timer_reset_input_o,
  output logic            spi_ss_o,
  output logic            spi_miso_o,
  output logic            spi_mosi_o,
  output logic            spi_sck_o
);

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] b_func;
    logic [7:0] c_func;
    logic [7:0] a_drive;
    logic [7:0] in_rdata;
  } gpcr_top_t;

  gpcr_top_t s_q;
  gpcr_top_t s_d;

  logic [7:0] b_dir;
  logic [7:0] b_sample;
  logic [7:0] b_pad;
  logic [7:0] b_oe;
  logic [7:0] c_pu;
  logic [7:0] c_opt;
  logic [7:0] c_dir;
  logic [7:0] c_sample;
  logic [7:0] c_pad;
  logic [7:0] c_oe;
  logic [7:0] c_pull;
  logic [7:0] c_weak;
  logic [7:0] a_sample;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // ---------------------------------------------------------------------------
  // Ports B and C
  // ---------------------------------------------------------------------------
  gpcr_port #(.WIDTH(8)) u_port_b (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .mask_i    (8'hFF),
    .pu_we_i   (1'b0),
    .or_we_i   (1'b0),
    .dir_we_i  (cfg_we_i &
                hit(cfg_addr_i, gpcr_pkg::PORT_B_DIRECTION_OFS)),
    .out_we_i  (out_we_i & hit(out_addr_i, gpcr_pkg::PORT_B_IDX)),
    .wdata_i   (cfg_we_i ? cfg_wdata_i : out_wdata_i),
    .pad_in_i  (port_b_pad_i),
    .pu_reg_o  (),
    .or_reg_o  (),
    .dir_o     (b_dir),
    .pad_o     (b_pad),
    .pad_oe_o  (b_oe),
    .pull_en_o (port_b_pull_en_o),
    .weak_o    (port_b_weak_o),
    .irq_en_o  (port_b_irq_en_o),
    .sample_o  (b_sample)
  );

  gpcr_port #(.WIDTH(8)) u_port_c (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .mask_i    (gpcr_pkg::PORT_C_MASK),
    .pu_we_i   (cfg_we_i &
                hit(cfg_addr_i, gpcr_pkg::PORT_C_PULLUP_ENABLE_OFS)),
    .or_we_i   (cfg_we_i &
                hit(cfg_addr_i, gpcr_pkg::PORT_C_MODE_OPTION_OFS)),
    .dir_we_i  (cfg_we_i &
                hit(cfg_addr_i, gpcr_pkg::PORT_C_DIRECTION_OFS)),
    .out_we_i  (out_we_i & hit(out_addr_i, gpcr_pkg::PORT_C_IDX)),
    .wdata_i   (cfg_we_i ? cfg_wdata_i : out_wdata_i),
    .pad_in_i  (port_c_pad_i),
    .pu_reg_o  (c_pu),
    .or_reg_o  (c_opt),
    .dir_o     (c_dir),
    .pad_o     (c_pad),
    .pad_oe_o  (c_oe),
    .pull_en_o (c_pull),
    .weak_o    (c_weak),
    .irq_en_o  (),
    .sample_o  (c_sample)
  );

  // ---------------------------------------------------------------------------
  // Register writes and read data
  // ---------------------------------------------------------------------------
  assign a_sample = (port_a_dir_i & s_q.a_drive) |
                    (~port_a_dir_i & port_a_pad_i);

  always_comb begin
    s_d = s_q;
    if (cfg_we_i && hit(cfg_addr_i, gpcr_pkg::PORT_B_FUNCTION_SELECT_OFS)) begin
      s_d.b_func = cfg_wdata_i;
    end
    if (cfg_we_i && hit(cfg_addr_i, gpcr_pkg::PORT_C_FUNCTION_SELECT_OFS)) begin
      s_d.c_func = cfg_wdata_i & gpcr_pkg::PORT_C_MASK;
    end
    if (out_we_i && hit(out_addr_i, gpcr_pkg::PORT_A_IDX)) begin
      s_d.a_drive = out_wdata_i;
    end
    unique case (in_addr_i)
      gpcr_pkg::PORT_A_IDX: s_d.in_rdata = a_sample;
      gpcr_pkg::PORT_B_IDX: s_d.in_rdata = b_sample;
      gpcr_pkg::PORT_C_IDX: s_d.in_rdata = c_sample;
      default:              s_d.in_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q.b_func   <= gpcr_pkg::CFG_RESET;
      s_q.c_func   <= gpcr_pkg::CFG_RESET;
      s_q.a_drive  <= gpcr_pkg::DRIVE_RESET;
      s_q.in_rdata <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    unique case (cfg_addr_i)
      gpcr_pkg::PORT_B_DIRECTION_OFS:       cfg_rdata_o = b_dir;
      gpcr_pkg::PORT_B_FUNCTION_SELECT_OFS: cfg_rdata_o = s_q.b_func;
      gpcr_pkg::PORT_C_PULLUP_ENABLE_OFS:   cfg_rdata_o = c_pu;
      gpcr_pkg::PORT_C_MODE_OPTION_OFS:     cfg_rdata_o = c_opt;
      gpcr_pkg::PORT_C_DIRECTION_OFS:       cfg_rdata_o = c_dir;
      gpcr_pkg::PORT_C_FUNCTION_SELECT_OFS: cfg_rdata_o = s_q.c_func;
      default:                              cfg_rdata_o = 8'h00;
    endcase
  end

  assign in_rdata_o   = s_q.in_rdata;
  assign port_a_pad_o = s_q.a_drive;

  // ---------------------------------------------------------------------------
  // Alternate functions
  // ---------------------------------------------------------------------------
  // An analog pin has its digital driver and pull-up released.
  assign port_b_analog_en_o = s_q.b_func;
  assign adc_vref_en_o      = s_q.b_func[gpcr_pkg::PB_VREF_BIT];
  assign port_b_pad_o       = b_pad;
  assign port_b_pad_oe_o    = b_oe & ~s_q.b_func;

  always_comb begin
    port_c_pad_o     = c_pad;
    port_c_pad_oe_o  = c_oe;
    port_c_pull_en_o = c_pull;
    port_c_weak_o    = c_weak;
    if (s_q.c_func[gpcr_pkg::PC_TX_BIT]) begin
      port_c_pad_o[gpcr_pkg::PC_TX_BIT] = uart_tx_i;
    end
    if (s_q.c_func[gpcr_pkg::PC_MISO_BIT]) begin
      port_c_pad_o[gpcr_pkg::PC_MISO_BIT] = spi_miso_i;
    end
    if (s_q.c_func[gpcr_pkg::PC_MOSI_BIT]) begin
      port_c_pad_o[gpcr_pkg::PC_MOSI_BIT] = spi_mosi_i;
    end
    if (s_q.c_func[gpcr_pkg::PC_SCK_BIT]) begin
      port_c_pad_o[gpcr_pkg::PC_SCK_BIT] = spi_sck_i;
    end
  end

  // Peripheral inputs read the raw pin only when routed, else idle low.
  assign timer_reset_input_o = s_q.c_func[gpcr_pkg::PC_TMR_RST_BIT] &
                               port_c_pad_i[gpcr_pkg::PC_TMR_RST_BIT];
  assign spi_ss_o   = s_q.c_func[gpcr_pkg::PC_SS_BIT] &
                      port_c_pad_i[gpcr_pkg::PC_SS_BIT];
  assign spi_miso_o = s_q.c_func[gpcr_pkg::PC_MISO_BIT] &
                      port_c_pad_i[gpcr_pkg::PC_MISO_BIT];
  assign spi_mosi_o = s_q.c_func[gpcr_pkg::PC_MOSI_BIT] &
                      port_c_pad_i[gpcr_pkg::PC_MOSI_BIT];
  assign spi_sck_o  = s_q.c_func[gpcr_pkg::PC_SCK_BIT] &
                      port_c_pad_i[gpcr_pkg::PC_SCK_BIT];

endmodule

/* File: test/gpcr_assertions.sv */
module gpcr_assertions (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic       cfg_we_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic [7:0] cfg_rdata_o,
  input wire logic [7:0] in_addr_i,
  input wire logic [7:0] in_rdata_o,
  input wire logic [7:0] out_addr_i,
  input wire logic       out_we_i,
  input wire logic [7:0] out_wdata_i,
  input wire logic [7:0] port_a_pad_i,
  input wire logic [7:0] port_a_dir_i,
  input wire logic [7:0] port_a_pad_o,
  input wire logic [7:0] port_b_pad_oe_o,
  input wire logic [7:0] port_b_analog_en_o,
  input wire logic [7:0] port_c_pad_o,
  input wire logic [7:0] port_c_pad_oe_o,
  input wire logic [7:0] port_c_pull_en_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence cfg_wr_s(a);
    cfg_we_i && cfg_addr_i == a;
  endsequence
  sequence out_wr_s(a);
    out_we_i && out_addr_i == a;
  endsequence

  rst_clear_a: assert property (
    $fell(rst_i) |-> port_a_pad_o == 8'h00 && port_c_pad_oe_o == 8'h00
      && port_b_analog_en_o == 8'h00)
    else $error("state not clear after reset");
  unmapped_read_a: assert property (
    !(cfg_addr_i inside {[8'h1E:8'h23]}) |-> cfg_rdata_o == 8'h00)
    else $error("unmapped config read not zero");
  c_upper_read_a: assert property (
    cfg_addr_i inside {[8'h20:8'h23]} |-> cfg_rdata_o[7:6] == 2'h0)
    else $error("port C upper bits read nonzero");
  b_select_write_a: assert property (
    cfg_wr_s(8'h1F) |=> port_b_analog_en_o == $past(cfg_wdata_i))
    else $error("port B select write lost");
  latch_hold_a: assert property (
    cfg_wr_s(8'h20) or cfg_wr_s(8'h21) |=>
      $stable(port_c_pull_en_o) && $stable(port_c_pad_oe_o))
    else $error("pin setup changed before direction write");
  dir_clear_a: assert property (
    cfg_we_i && cfg_addr_i == 8'h22 && cfg_wdata_i == 8'h00
      |=> port_c_pad_oe_o == 8'h00)
    else $error("port C pins driven after direction cleared");
  a_drive_a: assert property (
    out_wr_s(8'h00) |=> port_a_pad_o == $past(out_wdata_i))
    else $error("port A drive not updated");
  a_sample_a: assert property (
    in_addr_i == 8'h00 && port_a_dir_i == 8'h00
      |=> in_rdata_o == $past(port_a_pad_i))
    else $error("port A sample wrong");
  b_analog_off_a: assert property (
    (port_b_analog_en_o & port_b_pad_oe_o) == 8'h00)
    else $error("analog pin driven");
  c_upper_pins_a: assert property (
    ((port_c_pad_oe_o | port_c_pad_o | port_c_pull_en_o) & 8'hC0) == 8'h00)
    else $error("port C upper pins active");
endmodule

bind gpcr_top gpcr_assertions u_chk (.*);

/* File: test/gpcr_pins.sv */
module gpcr_pins (
  input  wire logic       clk_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] drv_i,
  input  wire logic [7:0] pull_i,
  input  wire logic [7:0] ext_i,
  input  wire logic [7:0] ext_en_i,
  output logic      [7:0] pad_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] float_q = 8'h55;

  // An undriven pin without pull-up wanders, so no level can be trusted.
  always @(posedge clk_i) begin
    float_q <= ~float_q;
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_o[i] = oe_i[i] ? drv_i[i] : ext_en_i[i] ? ext_i[i] :
                 pull_i[i] ? 1'b1 : float_q[i];
    end
  end
endmodule

/* File: test/test_port_config_and_data_regs.sv */
module test_port_config_and_data_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_i = 0, rst_i = 1, cfg_we_i = 0, out_we_i = 0;
  logic [7:0] cfg_addr_i = 0, cfg_wdata_i = 0, in_addr_i = 0;
  logic [7:0] out_addr_i = 0, out_wdata_i = 0;
  logic [7:0] port_a_pad_i = 0, port_a_dir_i = 0;
  logic [7:0] ext_b = 0, ext_c = 0, en_b = 0, en_c = 0;
  logic       uart_tx_i = 0, spi_miso_i = 0, spi_mosi_i = 0, spi_sck_i = 0;
  logic [7:0] cfg_rdata_o, in_rdata_o, port_a_pad_o, port_b_pad_i;
  logic [7:0] port_b_pad_o, port_b_pad_oe_o, port_b_pull_en_o;
  logic [7:0] port_b_weak_o, port_b_irq_en_o, port_b_analog_en_o;
  logic [7:0] port_c_pad_i, port_c_pad_o, port_c_pad_oe_o;
  logic [7:0] port_c_pull_en_o, port_c_weak_o;
  logic       adc_vref_en_o, timer_reset_input_o, spi_ss_o;
  logic       spi_miso_o, spi_mosi_o, spi_sck_o;
  int         err_total = 0, check_count = 0;

  always #50 clk_i = ~clk_i;

  gpcr_top DUT (.*);
  gpcr_pins u_pins_b (.clk_i(clk_i), .oe_i(port_b_pad_oe_o),
    .drv_i(port_b_pad_o), .pull_i(port_b_pull_en_o), .ext_i(ext_b),
    .ext_en_i(en_b), .pad_o(port_b_pad_i));
  gpcr_pins u_pins_c (.clk_i(clk_i), .oe_i(port_c_pad_oe_o),
    .drv_i(port_c_pad_o), .pull_i(port_c_pull_en_o), .ext_i(ext_c),
    .ext_en_i(en_c), .pad_o(port_c_pad_i));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cwr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    cfg_addr_i = a;
    cfg_wdata_i = d;
    cfg_we_i = 1;
    @(posedge clk_i);
    #1;
    cfg_we_i = 0;
  endtask
  task automatic owr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    out_addr_i = a;
    out_wdata_i = d;
    out_we_i = 1;
    @(posedge clk_i);
    #1;
    out_we_i = 0;
  endtask
  task automatic crd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    #1;
    cfg_addr_i = a;
    #10;
    chk(cfg_rdata_o, e);
  endtask
  task automatic ird(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    #1;
    in_addr_i = a;
    @(posedge clk_i);
    #1;
    chk(in_rdata_o, e);
  endtask

  task automatic t_reset;
    for (int i = 8'h1E; i < 8'h24; i++) crd(8'(i), 8'h00);
    chk(port_a_pad_o, 8'h00);
    chk(port_c_pad_oe_o, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_regs;
    for (int i = 8'h1E; i < 8'h24; i++) begin
      cwr(8'(i), 8'hFF);
      crd(8'(i), (i < 8'h20) ? 8'hFF : 8'h3F);
    end
    cwr(8'h24, 8'hFF);
    crd(8'h24, 8'h00);
    for (int i = 8'h1E; i < 8'h24; i++) cwr(8'(i), 8'h00);
    $display("test registers done");
  endtask
  task automatic t_latch;
    cwr(8'h20, 8'h3F);
    chk(port_c_pull_en_o, 8'h00);
    cwr(8'h22, 8'h00);
    chk(port_c_pull_en_o, 8'h3F);
    for (int m = 0; m < 8; m++) begin
      cwr(8'h20, m[2] ? 8'h3F : 8'h00);
      cwr(8'h21, m[1] ? 8'h3F : 8'h00);
      cwr(8'h22, m[0] ? 8'hFF : 8'h00);
      chk(port_c_pad_oe_o, m[0] ? 8'h3F : 8'h00);
      chk(port_c_weak_o, (m == 7) ? 8'h3F : 8'h00);
      if (m != 7) chk(port_c_pull_en_o, m[2] ? 8'h3F : 8'h00);
    end
    owr(8'h02, 8'hEA);
    chk(port_c_pad_oe_o, 8'h3F);
    cwr(8'h20, 8'h00);
    cwr(8'h21, 8'h00);
    cwr(8'h22, 8'h3F);
    chk(port_c_pad_o, 8'h2A);
    ird(8'h02, 8'h2A);
    cwr(8'h22, 8'h00);
    $display("test pin modes done");
  endtask
  task automatic t_input;
    ext_b = 8'hC3;
    en_b = 8'hFF;
    cwr(8'h1E, 8'h0F);
    owr(8'h01, 8'h5A);
    chk(port_b_pad_oe_o, 8'h0F);
    chk(port_b_pad_o, 8'h5A);
    ird(8'h01, 8'hCA);
    port_a_pad_i = 8'hA5;
    ird(8'h00, 8'hA5);
    owr(8'h00, 8'h3C);
    chk(port_a_pad_o, 8'h3C);
    port_a_dir_i = 8'hF0;
    ird(8'h00, 8'h35);
    ext_c = 8'hE9;
    en_c = 8'hFF;
    ird(8'h02, 8'h29);
    ird(8'h03, 8'h00);
    $display("test data registers done");
  endtask
  task automatic t_af;
    cwr(8'h1F, 8'h81);
    chk(port_b_analog_en_o, 8'h81);
    chk({7'h00, adc_vref_en_o}, 8'h01);
    chk(port_b_pad_oe_o, 8'h0E);
    chk({3'h0, timer_reset_input_o, spi_ss_o, spi_miso_o, spi_mosi_o,
         spi_sck_o}, 8'h00);
    cwr(8'h23, 8'h3F);
    chk({3'h0, timer_reset_input_o, spi_ss_o, spi_miso_o, spi_mosi_o,
         spi_sck_o}, 8'h19);
    cwr(8'h22, 8'h3F);
    owr(8'h02, 8'h00);
    uart_tx_i = 1;
    spi_sck_i = 1;
    spi_miso_i = 1;
    #10;
    chk(port_c_pad_o, 8'h15);
    cwr(8'h23, 8'h00);
    cwr(8'h20, 8'h3F);
    cwr(8'h21, 8'h00);
    cwr(8'h22, 8'h00);
    chk(port_c_pull_en_o, 8'h3F);
    chk(port_c_pad_oe_o, 8'h00);
    $display("test alternate functions done");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #1000000;
    err_total++;
    give_verdict;
  end

  initial begin
    repeat (3) @(posedge clk_i);
    #1;
    rst_i = 0;
    t_reset;
    t_regs;
    t_latch;
    t_input;
    t_af;
    give_verdict;
  end
endmodule
